// >>> hdl/sflash_pkg.sv
// shared constants and types for the serial sector flash control
package sflash_pkg;
  localparam int SECTOR_BYTES = 536;
  localparam int SMALL_SECTORS = 2048;
  localparam int LARGE_SECTORS = 4096;
  localparam int BLOCK_SECTORS = 32;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  // synchronised input positions
  localparam int IN_SCK = 0;
  localparam int IN_CS = 1;
  localparam int IN_SI = 2;
  localparam int IN_HOLD = 3;
  localparam int IN_WP = 4;
  localparam int IN_COUNT = 5;
  // idle levels: wp high, hold high, si low, cs high, sck low
  localparam logic [4:0] SYNC_RESET = 5'h1A;
  // last header byte: opcode, sector hi/lo, offset hi/lo
  localparam logic [2:0] HEAD_LAST = 3'h4;
  localparam logic [3:0] RANGE_NONE = 4'h0;
  localparam logic [3:0] RANGE_ALL = 4'hF;
  // status byte positions
  localparam int ST_READY = 7;
  localparam int ST_ERASE = 6;
  localparam int ST_WRITE = 5;
  localparam int ST_REFUSED = 4;
  localparam logic RESULT_RESET = 1'b0;
  // opcodes
  localparam logic [7:0] CMD_READ_SECTOR = 8'h52;
  localparam logic [7:0] CMD_WRITE_SECTOR = 8'h57;
  localparam logic [7:0] CMD_WRITE_NOERASE = 8'h50;
  localparam logic [7:0] CMD_XFER_SRAM = 8'h54;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h45;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h42;
  localparam logic [7:0] CMD_WRITE_SRAM = 8'h53;
  localparam logic [7:0] CMD_READ_SRAM = 8'h4D;
  localparam logic [7:0] CMD_READ_STATUS = 8'h44;
  typedef enum logic [1:0] {
    PIN_NC = 2'b00, PIN_HOLD = 2'b01, PIN_RB = 2'b10
  } pin_mode_t;
  typedef enum logic [1:0] {
    ARR_ERASE = 2'b00, ARR_ERASE_BLK = 2'b01,
    ARR_PROG = 2'b10, ARR_PROG_ERASE = 2'b11
  } arr_op_t;
  typedef enum logic [1:0] {
    LK_IDLE = 2'b00, LK_HEAD = 2'b01, LK_DATA = 2'b10, LK_DROP = 2'b11
  } link_st_t;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00, OP_STREAM = 2'b01, OP_WAIT = 2'b10
  } op_st_t;
endpackage

// >>> hdl/spi_sector_flash_control.sv
// serial sector flash control: link decoder, sram buffer, array sequencer
`timescale 1ns/1ns

module sflash_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_b,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t f;
  fifo_st_t next_f;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign inReady = f.cnt != (AW+1)'(DEPTH);
  assign outValid = f.cnt != '0;
  assign outData = mem[f.rp];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_f = f;
    if (push) begin
      next_f.wp = f.wp + 1'b1;
    end
    if (pop) begin
      next_f.rp = f.rp + 1'b1;
    end
    next_f.cnt = f.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[f.wp] <= inData;
    end
  end
endmodule

module spi_sector_flash_control #(
  parameter bit LARGE_PART = 1'b0
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_b,
  // serial link
  input wire logic sck,
  input wire logic csB,
  input wire logic si,
  output logic soOut,
  output logic soOe,
  // write protect and multifunction pin
  input wire logic wpB,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  // configuration
  input wire logic readEdgeSelect,
  input wire sflash_pkg::pin_mode_t pinMode,
  input wire logic [3:0] protRange,
  input wire logic protFromEnd,
  // status
  output logic ready,
  output logic eraseResultBit,
  output logic writeResultBit,
  output logic refused,
  output logic standby,
  // flash array
  output logic arrOpStart,
  output sflash_pkg::arr_op_t arrOp,
  output logic [11:0] arrSector,
  input wire logic arrOpDone,
  input wire logic arrEraseOk,
  input wire logic arrWriteOk,
  output logic arrRdEn,
  output logic [9:0] arrRdByte,
  input wire logic [7:0] arrRdData,
  // program data stream
  output logic progValid,
  output logic [7:0] progData,
  input wire logic progReady
);
  import sflash_pkg::*;

  typedef struct packed {
    logic [IN_COUNT-1:0] s0;
    logic [IN_COUNT-1:0] s1;
    logic [IN_COUNT-1:0] s2;
    logic [IN_COUNT-1:0] lvl;
    logic armed;
    link_st_t lk;
    logic [2:0] bitCnt;
    logic [2:0] byteCnt;
    logic [2:0] outCnt;
    logic [7:0] shIn;
    logic [7:0] shOut;
    logic [7:0] cmd;
    logic [15:0] sector;
    logic [15:0] offs;
    logic firstOut;
    logic so;
    logic soOe;
    op_st_t op;
    arr_op_t kind;
    logic [11:0] arrSec;
    logic [9:0] streamIdx;
    logic busy;
    logic rdy;
    logic eraseRes;
    logic writeRes;
    logic refused;
    logic start;
    logic rdEn;
    logic pinOut;
    logic pinOe;
    logic standby;
  } state_t;

  localparam state_t ST_RESET = '{s0: SYNC_RESET, s1: SYNC_RESET,
    s2: SYNC_RESET, lvl: SYNC_RESET, lk: LK_IDLE, op: OP_IDLE,
    kind: ARR_ERASE, rdy: 1'b1, pinOut: 1'b1, eraseRes: RESULT_RESET,
    writeRes: RESULT_RESET, default: '0};
  localparam logic [12:0] SECTOR_COUNT = LARGE_PART ?
    13'(LARGE_SECTORS) : 13'(SMALL_SECTORS);

  state_t st;
  state_t next_st;
  logic [7:0] sram [SECTOR_BYTES];
  logic [IN_COUNT-1:0] fl;
  logic held, sel, rise, fall, csRise, csFall, outEdge;
  logic isRead, isWrData, isArray, offOk;
  logic [7:0] byteIn, outByte, statusByte, streamByte;
  logic [11:0] tgtSector;
  arr_op_t cmdKind;
  logic sramWr;
  logic fifoIn;
  logic fifoRdy;

  // a level counts once stages two and three agree; needs sck <= 16 MHz
  generate
    for (genvar i = 0; i < IN_COUNT; i++) begin : g_filt
      assign fl[i] = (st.s1[i] == st.s2[i]) ? st.s2[i] : st.lvl[i];
    end
  endgenerate

  function automatic logic prot_hit(input logic [11:0] sec);
    logic [12:0] span;
    span = {4'h0, protRange, 5'h00};
    if ({1'b0, sec} >= SECTOR_COUNT) begin
      return 1'b1;
    end else if (protRange == RANGE_ALL) begin
      return 1'b1;
    end else if (protRange == RANGE_NONE) begin
      return 1'b0;
    end else if (protFromEnd) begin
      return {1'b0, sec} >= SECTOR_COUNT - span;
    end
    return {1'b0, sec} < span;
  endfunction

  assign held = (pinMode == PIN_HOLD) && !fl[IN_HOLD];
  assign sel = !fl[IN_CS] && !held;
  assign rise = sel && fl[IN_SCK] && !st.lvl[IN_SCK];
  assign fall = sel && !fl[IN_SCK] && st.lvl[IN_SCK];
  assign csRise = fl[IN_CS] && !st.lvl[IN_CS];
  assign csFall = !fl[IN_CS] && st.lvl[IN_CS];
  assign byteIn = {st.shIn[6:0], fl[IN_SI]};
  assign offOk = st.offs < 16'(SECTOR_BYTES);
  assign isRead = st.cmd == CMD_READ_SECTOR || st.cmd == CMD_READ_SRAM ||
    st.cmd == CMD_READ_STATUS;
  assign isWrData = st.cmd == CMD_WRITE_SECTOR ||
    st.cmd == CMD_WRITE_NOERASE || st.cmd == CMD_WRITE_SRAM;
  assign isArray = st.cmd == CMD_WRITE_SECTOR ||
    st.cmd == CMD_WRITE_NOERASE || st.cmd == CMD_XFER_SRAM ||
    st.cmd == CMD_ERASE_SECTOR || st.cmd == CMD_ERASE_BLOCK;
  assign outEdge = (readEdgeSelect ? rise : fall) &&
    st.lk == LK_DATA && isRead;
  assign streamByte = sram[st.streamIdx];
  // a link write to sram steals the port; the stream waits that cycle
  assign fifoIn = st.op == OP_STREAM && !sramWr;

  always_comb begin
    next_st = st;
    sramWr = 1'b0;
    statusByte = 8'h00;
    statusByte[ST_READY] = !st.busy;
    statusByte[ST_ERASE] = st.eraseRes;
    statusByte[ST_WRITE] = st.writeRes;
    statusByte[ST_REFUSED] = st.refused;
    tgtSector = st.sector[11:0];
    cmdKind = ARR_PROG_ERASE;
    case (st.cmd)
      CMD_ERASE_SECTOR: cmdKind = ARR_ERASE;
      CMD_ERASE_BLOCK: begin
        cmdKind = ARR_ERASE_BLK;
        tgtSector = st.sector[11:0] & ~12'(BLOCK_SECTORS - 1);
      end
      CMD_WRITE_NOERASE: cmdKind = ARR_PROG;
      default: cmdKind = ARR_PROG_ERASE;
    endcase
    if (st.cmd == CMD_READ_STATUS) begin
      outByte = statusByte;
    end else if (st.cmd == CMD_READ_SRAM) begin
      outByte = offOk ? sram[st.offs[9:0]] : 8'h00;
    end else if (st.firstOut) begin
      outByte = statusByte;
    end else begin
      outByte = st.rdEn ? arrRdData : 8'h00;
    end
    next_st.s0 = {wpB, pinIn, si, csB, sck};
    next_st.s1 = st.s0;
    next_st.s2 = st.s1;
    next_st.lvl = fl;
    next_st.start = 1'b0;
    // counters restart at select; sck is low then, so no stray edge
    if (csFall) begin
      next_st.lk = st.armed ? LK_HEAD : LK_DROP;
      next_st.bitCnt = 3'h0;
      next_st.byteCnt = 3'h0;
      next_st.outCnt = 3'h0;
      next_st.firstOut = 1'b1;
    end
    if (rise && (st.lk == LK_HEAD || st.lk == LK_DATA)) begin
      next_st.shIn = byteIn;
      next_st.bitCnt = st.bitCnt + 3'h1;
      if (st.bitCnt == 3'h7 && st.lk == LK_HEAD) begin
        next_st.byteCnt = st.byteCnt + 3'h1;
        case (st.byteCnt)
          3'h0: begin
            next_st.cmd = byteIn;
            if (byteIn == CMD_READ_STATUS) begin
              next_st.lk = LK_DATA;
            end
          end
          3'h1: next_st.sector[15:8] = byteIn;
          3'h2: next_st.sector[7:0] = byteIn;
          3'h3: next_st.offs[15:8] = byteIn;
          HEAD_LAST: begin
            next_st.offs[7:0] = byteIn;
            next_st.lk = LK_DATA;
            if (st.cmd == CMD_READ_SECTOR && !st.busy) begin
              next_st.rdEn = 1'b1;
              next_st.arrSec = st.sector[11:0];
            end
          end
          default: next_st.byteCnt = st.byteCnt;
        endcase
      end else if (st.bitCnt == 3'h7 && isWrData && offOk) begin
        sramWr = 1'b1;
        next_st.offs = st.offs + 16'h0001;
      end
    end
    if (outEdge) begin
      next_st.outCnt = st.outCnt + 3'h1;
      if (st.outCnt == 3'h0) begin
        next_st.so = outByte[7];
        next_st.shOut = {outByte[6:0], 1'b0};
        next_st.firstOut = 1'b0;
        if (st.cmd != CMD_READ_STATUS &&
            !(st.cmd == CMD_READ_SECTOR && st.firstOut)) begin
          next_st.offs = st.offs + 16'h0001;
        end
      end else begin
        next_st.so = st.shOut[7];
        next_st.shOut = {st.shOut[6:0], 1'b0};
      end
    end
    if (csRise) begin
      next_st.armed = 1'b1;
      next_st.lk = LK_IDLE;
      next_st.rdEn = 1'b0;
      // only a complete header reaches the data phase
      if (st.lk == LK_DATA && isArray) begin
        if (st.busy || !fl[IN_WP] || prot_hit(tgtSector)) begin
          next_st.refused = 1'b1;
        end else begin
          next_st.refused = 1'b0;
          next_st.busy = 1'b1;
          next_st.start = 1'b1;
          next_st.kind = cmdKind;
          next_st.arrSec = tgtSector;
          next_st.streamIdx = 10'h000;
          next_st.op = (cmdKind == ARR_PROG || cmdKind == ARR_PROG_ERASE) ?
            OP_STREAM : OP_WAIT;
        end
      end
    end
    if (st.op == OP_STREAM && fifoIn && fifoRdy) begin
      next_st.streamIdx = st.streamIdx + 10'h001;
      if (st.streamIdx == 10'(SECTOR_BYTES - 1)) begin
        next_st.op = OP_WAIT;
      end
    end
    if (st.op == OP_WAIT && arrOpDone) begin
      next_st.op = OP_IDLE;
      next_st.busy = 1'b0;
      if (st.kind != ARR_PROG) begin
        next_st.eraseRes = arrEraseOk;
      end
      if (st.kind == ARR_PROG || st.kind == ARR_PROG_ERASE) begin
        next_st.writeRes = arrWriteOk;
      end
    end
    next_st.soOe = sel;
    next_st.rdy = !next_st.busy;
    next_st.pinOe = pinMode == PIN_RB;
    next_st.pinOut = !next_st.busy;
    next_st.standby = fl[IN_CS] && !next_st.busy;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // memory carries no reset; contents are undefined until written
  always_ff @(posedge clk_sys) begin
    if (sramWr) begin
      sram[st.offs[9:0]] <= byteIn;
    end
  end

  sflash_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .inValid(fifoIn),
    .inReady(fifoRdy),
    .inData(streamByte),
    .outValid(progValid),
    .outReady(progReady),
    .outData(progData)
  );

  assign soOut = st.so;
  assign soOe = st.soOe;
  assign pinOut = st.pinOut;
  assign pinOe = st.pinOe;
  assign ready = st.rdy;
  assign eraseResultBit = st.eraseRes;
  assign writeResultBit = st.writeRes;
  assign refused = st.refused;
  assign standby = st.standby;
  assign arrOpStart = st.start;
  assign arrOp = st.kind;
  assign arrSector = st.arrSec;
  assign arrRdEn = st.rdEn;
  assign arrRdByte = st.offs[9:0];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence launch_s;
    arrOpStart && !ready;
  endsequence
  sequence still_busy_s;
    !arrOpStart && !ready;
  endsequence

  chk_so_idle: assert property (
    st.lvl[IN_CS] |-> !soOe) else $error("output driven while deselected");
  chk_si_sample: assert property (
    (rise && st.lk == LK_HEAD) |=> st.shIn[0] == $past(fl[IN_SI]))
    else $error("input bit not taken on rising edge");
  chk_edge_select: assert property (
    ($changed(soOut) && st.lk == LK_DATA) |-> $past(outEdge))
    else $error("output moved off the selected edge");
  chk_arm_first: assert property (
    !st.armed |-> !arrOpStart) else $error("command taken before arming");
  chk_standby_busy: assert property (
    standby |-> (st.lvl[IN_CS] && ready))
    else $error("standby while selected or busy");
  chk_wp_refuse: assert property (
    arrOpStart |-> st.lvl[IN_WP]) else $error("write under protect pin");
  chk_range_refuse: assert property (
    arrOpStart |-> !prot_hit(arrSector))
    else $error("write inside protected range");
  chk_busy_reject: assert property (
    launch_s |=> still_busy_s ##0 !arrRdEn)
    else $error("array used while busy");
  chk_pin_ready: assert property (
    (pinMode == PIN_RB) |=> (pinOe && pinOut == ready))
    else $error("ready pin wrong");
  chk_stream_len: assert property (
    $fell(st.op == OP_STREAM) |-> st.streamIdx == 10'(SECTOR_BYTES))
    else $error("sector stream length wrong");
  chk_auto_erase: assert property (
    (arrOpStart && st.cmd == CMD_WRITE_SECTOR) |-> arrOp == ARR_PROG_ERASE)
    else $error("sector write without erase");
  chk_verify_kept: assert property (
    (st.op == OP_WAIT && arrOpDone && arrOp != ARR_PROG) |=>
      eraseResultBit == $past(arrEraseOk))
    else $error("erase result not kept");
  chk_abandon_cmd: assert property (
    (csRise && st.lk == LK_HEAD) |=> !arrOpStart)
    else $error("partial command launched");
endmodule

// >>> tb/spi_host_model.sv
// host microcontroller model: master of the serial link
`timescale 1ns/1ns
module spi_host_model (
  // system
  input wire logic clk_sys,
  // serial link
  output logic sck,
  output logic csB,
  output logic si,
  input wire logic soOut,
  input wire logic soOe
);
  logic [7:0] rxByte = 8'h00;
  initial begin
    sck = 1'b0;
    csB = 1'b1;
    si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic select();
    sck <= 1'b0;
    tick(2);
    csB <= 1'b0;
    tick(5);
  endtask
  // the first deselect after power-up arms the device
  task automatic deselect();
    tick(5);
    csB <= 1'b1;
    si <= ~si; // a released line must not keep looking valid
    tick(10);
  endtask
  // five clocks a half period: 80 ns link period, under the maximum
  task automatic xfer(input logic [7:0] tx, input logic riseOut);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      // an undriven output line reads as the inverse of its last level
      tick(5);
      if (!riseOut) rxByte[i] = soOe ? soOut : ~soOut;
      sck <= 1'b1;
      tick(5);
      if (riseOut) rxByte[i] = soOe ? soOut : ~soOut;
      sck <= 1'b0;
    end
  endtask
endmodule

// >>> tb/spi_sector_flash_control_test.sv
// self-checking bench for the serial sector flash control
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failCount++; \
  $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end
module spi_sector_flash_control_test;
  import sflash_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic sck, csB, si, soOut, soOe, pinOut, pinOe;
  logic wpB = 1'b1;
  logic pinIn = 1'b1;
  logic readEdgeSelect = 1'b0;
  pin_mode_t pinMode = PIN_NC;
  logic [3:0] protRange = 4'h0;
  logic protFromEnd = 1'b1;
  logic ready, eraseResultBit, writeResultBit, refused, standby;
  logic arrOpStart, arrRdEn, progValid;
  arr_op_t arrOp;
  logic [11:0] arrSector;
  logic arrOpDone = 1'b0;
  logic arrEraseOk = 1'b0;
  logic arrWriteOk = 1'b0;
  logic progReady = 1'b1;
  logic [9:0] arrRdByte;
  logic [7:0] arrRdData, progData;
  int checked = 0;
  int failCount = 0;
  int cycles = 0;
  int starts = 0;
  arr_op_t lastOp;
  logic [11:0] lastSector;
  logic [10:0] progCount = 11'h000;
  logic [15:0] progHead = 16'h0000;
  logic [7:0] rx[4];

  always #4 clk_sys = ~clk_sys;

  spi_host_model host (.clk_sys(clk_sys), .sck(sck), .csB(csB), .si(si),
    .soOut(soOut), .soOe(soOe));

  spi_sector_flash_control dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .sck(sck), .csB(csB), .si(si), .soOut(soOut), .soOe(soOe),
    .wpB(wpB), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .readEdgeSelect(readEdgeSelect), .pinMode(pinMode),
    .protRange(protRange), .protFromEnd(protFromEnd), .ready(ready),
    .eraseResultBit(eraseResultBit), .writeResultBit(writeResultBit),
    .refused(refused), .standby(standby), .arrOpStart(arrOpStart),
    .arrOp(arrOp), .arrSector(arrSector), .arrOpDone(arrOpDone),
    .arrEraseOk(arrEraseOk), .arrWriteOk(arrWriteOk), .arrRdEn(arrRdEn),
    .arrRdByte(arrRdByte), .arrRdData(arrRdData), .progValid(progValid),
    .progData(progData), .progReady(progReady));

  // array read data is a known function of the byte address
  assign arrRdData = arrRdByte[7:0] ^ 8'h5A;

  always @(posedge clk_sys) begin
    if (arrOpStart) begin
      starts++;
      lastOp = arrOp;
      lastSector = arrSector;
      progCount = 11'h000;
    end else if (progValid && progReady) begin
      if (progCount < 11'h002) progHead = {progHead[7:0], progData};
      progCount = progCount + 11'h001;
    end
  end

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      failCount++;
      tally_and_finish();
    end
  end

  task automatic frame(input logic [7:0] op, input logic [15:0] sec,
    input logic [15:0] off, input int nb, input logic [7:0] wd);
    host.select();
    host.xfer(op, readEdgeSelect);
    if (op != CMD_READ_STATUS) begin
      host.xfer(sec[15:8], readEdgeSelect);
      host.xfer(sec[7:0], readEdgeSelect);
      host.xfer(off[15:8], readEdgeSelect);
      host.xfer(off[7:0], readEdgeSelect);
    end
    for (int i = 0; i < nb; i++) begin
      host.xfer(wd + 8'(i), readEdgeSelect);
      rx[i] = host.rxByte;
    end
    host.deselect();
  endtask

  // the bench lets program ops drain the whole sector before raising done
  task automatic finish_op(input logic eOk, input logic wOk, input bit prog);
    int n;
    n = 0;
    while (prog && progCount != 11'h218 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (prog) `CHK(progCount, 11'h218)
    arrEraseOk <= eOk;
    arrWriteOk <= wOk;
    arrOpDone <= 1'b1;
    @(posedge clk_sys);
    arrOpDone <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK(ready, 1'b1)
  endtask

  task automatic t_reset();
    `CHK({ready, soOe, eraseResultBit}, 3'h4)
    `CHK(standby, 1'b1)
    frame(CMD_ERASE_SECTOR, 16'h0009, 16'h0000, 0, 8'h00);
    `CHK(starts, 0)
    $display("test reset done");
  endtask

  task automatic t_write();
    int n0;
    n0 = starts;
    pinMode <= PIN_RB;
    progReady <= 1'b0; // stall so the buffer fills and refuses
    frame(CMD_WRITE_SECTOR, 16'h0005, 16'h0000, 2, 8'h10);
    `CHK(starts, n0 + 1)
    `CHK(lastOp, ARR_PROG_ERASE)
    `CHK(lastSector, 12'h005)
    `CHK(ready, 1'b0)
    `CHK({pinOe, pinOut}, 2'h2)
    `CHK(standby, 1'b0)
    frame(CMD_READ_STATUS, 16'h0000, 16'h0000, 1, 8'h00);
    `CHK(rx[0][ST_READY], 1'b0)
    // a sector read while busy returns status then zero bytes
    frame(CMD_READ_SECTOR, 16'h0009, 16'h0105, 2, 8'h00);
    `CHK({rx[0][ST_READY], rx[1]}, 9'h000)
    frame(CMD_WRITE_SRAM, 16'h0000, 16'h0007, 1, 8'h3C);
    frame(CMD_READ_SRAM, 16'h0000, 16'h0007, 1, 8'h00);
    `CHK(rx[0], 8'h3C)
    frame(CMD_ERASE_SECTOR, 16'h0009, 16'h0000, 0, 8'h00);
    `CHK({starts == n0 + 1, refused}, 2'h3)
    progReady <= 1'b1;
    finish_op(1'b1, 1'b0, 1'b1);
    `CHK({eraseResultBit, writeResultBit}, 2'h2)
    `CHK({standby, pinOut}, 2'h3)
    `CHK(progHead, 16'h1011)
    frame(CMD_READ_STATUS, 16'h0000, 16'h0000, 1, 8'h00);
    `CHK({rx[0][ST_ERASE], rx[0][ST_WRITE]}, 2'h2)
    $display("test write done");
  endtask

  task automatic t_protect();
    int n0;
    n0 = starts;
    wpB <= 1'b0;
    frame(CMD_ERASE_SECTOR, 16'h0064, 16'h0000, 0, 8'h00);
    `CHK({starts == n0, refused}, 2'h3)
    wpB <= 1'b1;
    protRange <= 4'h1;
    protFromEnd <= 1'b0;
    frame(CMD_ERASE_SECTOR, 16'h001F, 16'h0000, 0, 8'h00);
    `CHK({starts == n0, refused}, 2'h3)
    protFromEnd <= 1'b1;
    frame(CMD_ERASE_SECTOR, 16'h07E0, 16'h0000, 0, 8'h00);
    `CHK({starts == n0, refused}, 2'h3)
    frame(CMD_ERASE_SECTOR, 16'h0800, 16'h0000, 0, 8'h00);
    `CHK({starts == n0, refused}, 2'h3)
    frame(CMD_ERASE_SECTOR, 16'h0020, 16'h0000, 0, 8'h00);
    `CHK({starts == n0 + 1, refused}, 2'h2)
    `CHK(lastOp, ARR_ERASE)
    finish_op(1'b1, 1'b1, 1'b0);
    protRange <= 4'h0;
    $display("test protect done");
  endtask

  task automatic t_cmds();
    int n0;
    logic [7:0] ops[3] = '{CMD_ERASE_BLOCK, CMD_WRITE_NOERASE, CMD_XFER_SRAM};
    arr_op_t kinds[3] = '{ARR_ERASE_BLK, ARR_PROG, ARR_PROG_ERASE};
    logic [11:0] secs[3] = '{12'h025, 12'h006, 12'h007};
    logic [11:0] want[3] = '{12'h020, 12'h006, 12'h007};
    for (int i = 0; i < 3; i++) begin
      n0 = starts;
      frame(ops[i], {4'h0, secs[i]}, 16'h0000, 0, 8'h00);
      `CHK(starts, n0 + 1)
      `CHK(lastOp, kinds[i])
      `CHK(lastSector, want[i])
      finish_op(1'b1, 1'b1, i > 0);
    end
    n0 = starts;
    host.select();
    host.xfer(CMD_ERASE_SECTOR, 1'b0);
    host.xfer(8'h00, 1'b0);
    host.deselect();
    `CHK(starts, n0)
    $display("test commands done");
  endtask

  task automatic t_read();
    for (int e = 0; e < 2; e++) begin
      readEdgeSelect <= e[0];
      @(posedge clk_sys);
      frame(CMD_READ_SECTOR, 16'h0009, 16'h0105, 3, 8'h00);
      `CHK(rx[0][ST_READY], 1'b1)
      `CHK(rx[1], 8'h5F)
      `CHK(rx[2], 8'h5C)
      `CHK(soOe, 1'b0)
    end
    readEdgeSelect <= 1'b0;
    $display("test read done");
  endtask

  task automatic t_hold();
    pinMode <= PIN_HOLD;
    host.select();
    host.tick(5);
    `CHK(soOe, 1'b1)
    pinIn <= 1'b0;
    host.tick(8);
    `CHK(soOe, 1'b0)
    pinIn <= 1'b1;
    host.deselect();
    pinMode <= PIN_NC;
    host.tick(3);
    `CHK(pinOe, 1'b0)
    $display("test hold done");
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_write();
    t_protect();
    t_cmds();
    t_read();
    t_hold();
    tally_and_finish();
  end
endmodule
